// *** bench/mcr_cfg_props.sv ***
// Port checker for the modem configuration register bank
`timescale 1ns/1ns

module mcr_cfg_chk (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Bus and timing
  input wire s_axi_bvalid,
  input wire modem_clk_en,
  input wire bit_clk_in,
  input wire upper_band,
  input wire adc_clk_en,
  input wire baud_tick,
  input wire bit_clock_output,
  input wire tx_bit_valid,
  input wire tx_line_valid,
  // Decoded configuration
  input wire uart_mode,
  input wire tx_shaping,
  input wire ook_mode,
  input wire [2:0] tx_dev_exponent,
  input wire [3:0] tx_dev_mantissa,
  input wire [4:0] tx_dev_offset,
  input wire afc_enable,
  input wire [2:0] afc_pairs
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // Outputs still carry reset values at the first edge after release
  reg up;
  reg [3:0] en_cnt;
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      up <= 1'b0;
      en_cnt <= 4'h0;
    end
    else
    begin
      up <= 1'b1;
      en_cnt <= baud_tick ? 4'h0 : en_cnt + {3'h0, modem_clk_en};
    end
  end
  defaults_ok_a: assert property (!up |=> tx_shaping && tx_dev_exponent == 3'h6 &&
    tx_dev_mantissa == 4'h8 && afc_enable && afc_pairs == 3'h2) else $error("reset defaults not loaded");
  ook_sel_a: assert property (up |-> ook_mode == (tx_dev_mantissa == 4'h0))
    else $error("on-off keying select wrong");
  afc_sel_a: assert property (up |-> afc_enable ?
    afc_pairs inside {3'h1, 3'h2, 3'h4} : afc_pairs == 3'h0) else $error("averaging pairs wrong");
  band_ofs_a: assert property (up && $stable(upper_band) |->
    tx_dev_offset == (upper_band ? 5'h0F : 5'h10)) else $error("deviation offset wrong");
  bclk_follow_a: assert property (up && !uart_mode && !$past(uart_mode) |->
    bit_clock_output == $past(bit_clk_in)) else $error("bit clock not following");
  uart_hold_a: assert property ((uart_mode && !s_axi_bvalid) [*3] |-> $stable(bit_clock_output))
    else $error("bit clock moved in uart format");
  adc_rate_a: assert property (adc_clk_en |-> ##[1:16] adc_clk_en)
    else $error("adc clock too slow");
  baud_div_a: assert property (baud_tick |-> en_cnt == 4'h7 || en_cnt == 4'h8)
    else $error("baud tick spacing wrong");
  tx_lat_a: assert property (tx_bit_valid |-> ##2 tx_line_valid)
    else $error("transmit bit lost");
  cover property (ook_mode && !tx_shaping);
  cover property (uart_mode && bit_clock_output);
  cover property (baud_tick);
endmodule

bind mcr_modem_config mcr_cfg_chk mcr_cfg_chk_i (
  .core_clk(core_clk), .rst_n(rst_n), .s_axi_bvalid(s_axi_bvalid), .modem_clk_en(modem_clk_en),
  .bit_clk_in(bit_clk_in), .upper_band(upper_band), .adc_clk_en(adc_clk_en), .baud_tick(baud_tick),
  .bit_clock_output(bit_clock_output), .tx_bit_valid(tx_bit_valid), .tx_line_valid(tx_line_valid),
  .uart_mode(uart_mode), .tx_shaping(tx_shaping), .ook_mode(ook_mode), .tx_dev_exponent(tx_dev_exponent),
  .tx_dev_mantissa(tx_dev_mantissa), .tx_dev_offset(tx_dev_offset), .afc_enable(afc_enable),
  .afc_pairs(afc_pairs)
);

// *** bench/mcr_cfg_tb.sv ***
// Self-checking bench for the modem configuration register bank
`timescale 1ns/1ns

module testbench;
  logic core_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, modem_clk_en, bit_clk_in, upper_band, adc_clk_en;
  logic adc_clk, baud_tick, bit_clock_output, tx_bit, tx_bit_valid, tx_line, tx_line_valid, rx_bit, rx_bit_valid;
  logic rx_data, rx_data_valid, manchester_mode, uart_mode, tx_shaping, ook_mode, afc_enable;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, tx_dev_mantissa, rx_dev_mantissa;
  logic [1:0] s_axi_bresp, s_axi_rresp, rx_dev_exponent;
  logic [2:0] tx_dev_exponent, afc_pairs;
  logic [4:0] tx_dev_offset;
  int mismatches, checks_done;

  mcr_modem_config mcr_modem_config_i (
    .core_clk(core_clk), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .modem_clk_en(modem_clk_en), .bit_clk_in(bit_clk_in), .upper_band(upper_band), .adc_clk_en(adc_clk_en),
    .adc_clk(adc_clk), .baud_tick(baud_tick), .bit_clock_output(bit_clock_output),
    .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid), .tx_line(tx_line), .tx_line_valid(tx_line_valid),
    .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .rx_data(rx_data), .rx_data_valid(rx_data_valid),
    .manchester_mode(manchester_mode), .uart_mode(uart_mode), .tx_shaping(tx_shaping), .ook_mode(ook_mode),
    .tx_dev_exponent(tx_dev_exponent), .tx_dev_mantissa(tx_dev_mantissa), .tx_dev_offset(tx_dev_offset),
    .afc_enable(afc_enable), .afc_pairs(afc_pairs), .rx_dev_exponent(rx_dev_exponent),
    .rx_dev_mantissa(rx_dev_mantissa)
  );

  initial
  begin
    core_clk = 0;
    forever #10 core_clk = ~core_clk;
  end
  // Modem clock enable every other cycle, bit clock toggling slower
  always @(posedge core_clk)
  begin
    modem_clk_en <= ~modem_clk_en;
    if (modem_clk_en)
      bit_clk_in <= ~bit_clk_in;
  end

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
  begin
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
  begin
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
    repeat (2) @(posedge core_clk);
  end
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
  begin
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", exp, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
    @(posedge core_clk);
  end
  endtask

  task t_regs;
  begin
    rd(8'h34, 32'h30, 2'h0);
    rd(8'h38, 32'hE8, 2'h0);
    rd(8'h3C, 32'h9C, 2'h0);
    chk("rx dev", 32'h1C, {rx_dev_exponent, rx_dev_mantissa});
    wr(8'h34, 32'h77, 4'hF, 2'h0);
    rd(8'h34, 32'h77, 2'h0);
    wr(8'h34, 32'h0, 4'h0, 2'h0);
    rd(8'h34, 32'h77, 2'h0);
    wr(8'h40, 32'h0, 4'hF, 2'h2);
    wr(8'h44, 32'h0, 4'hF, 2'h2);
    rd(8'h44, 32'h0, 2'h2);
    $display("register access test done");
  end
  endtask

  task t_fmt;
    int f;
  begin
    for (f = 0; f < 4; f++)
    begin
      wr(8'h34, 32'h30 | f, 4'hF, 2'h0);
      chk("manchester", f == 1, manchester_mode);
      chk("uart", f > 1, uart_mode);
      if (f > 1)
        chk("bit clock", f - 2, bit_clock_output);
    end
    $display("format test done");
  end
  endtask

  task t_adc;
    int c, n, k;
  begin
    for (c = 0; c < 8; c++)
    begin
      wr(8'h34, c << 4, 4'hF, 2'h0);
      // First pass only aligns to a pulse
      for (k = 0; k < 2; k++)
      begin
        n = 0;
        do
        begin
          @(posedge core_clk);
          n++;
        end
        while (!adc_clk_en);
      end
      chk("adc period", c == 0 ? 8 : 2 * c + 2, n);
      chk("adc clock", 1, adc_clk);
    end
    $display("adc divisor test done");
  end
  endtask

  task t_dev;
  begin
    wr(8'h38, 32'h0, 4'hF, 2'h0);
    chk("shape ook", 2'b01, {tx_shaping, ook_mode});
    wr(8'h38, 32'hDA, 4'hF, 2'h0);
    chk("shape ook", 2'b10, {tx_shaping, ook_mode});
    chk("tx dev", 32'h5A, {tx_dev_exponent, tx_dev_mantissa});
    upper_band <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("upper offset", 32'hF, tx_dev_offset);
    upper_band <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("lower offset", 32'h10, tx_dev_offset);
    $display("deviation test done");
  end
  endtask

  task t_afc;
    int s;
  begin
    for (s = 0; s < 4; s++)
    begin
      // The loop ends on settling code 3, the preferred one
      wr(8'h3C, (s << 6) | 32'h39, 4'hF, 2'h0);
      chk("afc enable", s != 0, afc_enable);
      chk("afc pairs", s == 3 ? 4 : s, afc_pairs);
      chk("rx dev", 32'h39, {rx_dev_exponent, rx_dev_mantissa});
    end
    $display("frequency correction test done");
  end
  endtask

  task t_scr;
    int e, i, n;
    logic [8:0] pn;
    logic bc;
  begin
    // Plain NRZ, scrambled NRZ, then Manchester without scrambling
    for (e = 0; e < 3; e++)
    begin
      wr(8'h34, e == 1 ? 32'h34 : (e == 2 ? 32'h31 : 32'h30), 4'hF, 2'h0);
      pn = 9'h1FF;
      bc = 1'b0;
      for (i = 0; i < 12; i++)
      begin
        tx_bit <= i[0];
        rx_bit <= i[1];
        tx_bit_valid <= 1'b1;
        rx_bit_valid <= 1'b1;
        @(posedge core_clk);
        tx_bit_valid <= 1'b0;
        rx_bit_valid <= 1'b0;
        n = 0;
        do
        begin
          @(posedge core_clk);
          n++;
          // Bit clock level that the line coder samples at this edge
          if (n == 1)
            bc = bit_clk_in;
        end
        while (!tx_line_valid && n < 4);
        chk("bit valids", 2'b11, {tx_line_valid, rx_data_valid});
        chk("tx line", i[0] ^ ((e == 1) & pn[8]) ^ ((e == 2) & bc), tx_line);
        chk("rx data", i[1] ^ ((e == 1) & pn[8]), rx_data);
        pn = {pn[7:0], pn[8] ^ pn[4]};
      end
    end
    $display("scrambler test done");
  end
  endtask

  task t_baud;
    int n;
  begin
    do @(posedge core_clk); while (!baud_tick);
    n = 0;
    do
    begin
      @(posedge core_clk);
      n += modem_clk_en;
    end
    while (!baud_tick);
    chk("enables per baud", 8, n);
    $display("baud tick test done");
  end
  endtask

  task tally_and_finish;
  begin
    $display("comparisons %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask

  // Whole run needs about five hundred cycles; forty times that is a hang
  initial
  begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    tally_and_finish;
  end

  initial
  begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {modem_clk_en, bit_clk_in, upper_band, tx_bit, tx_bit_valid, rx_bit, rx_bit_valid} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    mismatches = 0;
    checks_done = 0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_regs;
    t_fmt;
    t_adc;
    t_dev;
    t_afc;
    t_scr;
    t_baud;
    tally_and_finish;
  end
endmodule

// *** hw/mcr_consts.vh ***
// Constants for the modem configuration register bank
`ifndef MCR_CONSTS_VH
`define MCR_CONSTS_VH

// Register indices and their AXI byte addresses (index times four)
`define MCR_IDX_MODEM 8'h0D
`define MCR_IDX_DEV 8'h0E
`define MCR_IDX_AFC 8'h0F
`define MCR_IDX_STATUS 8'h10
`define MCR_ADDR_MODEM 8'h34
`define MCR_ADDR_DEV 8'h38
`define MCR_ADDR_AFC 8'h3C
`define MCR_ADDR_STATUS 8'h40
`define MCR_ADDR_W 8

// Reset values
`define MCR_RST_MODEM 8'h30
`define MCR_RST_DEV 8'hE8
`define MCR_RST_AFC 8'h9C

// Field masks and positions
`define MCR_MODEM_WMASK 8'h77
`define MCR_ADC_HI 6
`define MCR_ADC_LO 4
`define MCR_SCR_BIT 2
`define MCR_FMT_HI 1
`define MCR_FMT_LO 0
`define MCR_SHAPE_BIT 7
`define MCR_TXX_HI 6
`define MCR_TXX_LO 4
`define MCR_TXM_HI 3
`define MCR_TXM_LO 0
`define MCR_SET_HI 7
`define MCR_SET_LO 6
`define MCR_RXX_HI 5
`define MCR_RXX_LO 4
`define MCR_RXM_HI 3
`define MCR_RXM_LO 0

// Encodings
`define MCR_FMT_NRZ 2'h0
`define MCR_FMT_MAN 2'h1
`define MCR_FMT_UART0 2'h2
`define MCR_FMT_UART1 2'h3
`define MCR_ADC_UNSUP 3'h0
`define MCR_ADC_FALLBACK 3'h3
`define MCR_SET_OFF 2'h0
`define MCR_SET_ONE 2'h1
`define MCR_SET_TWO 2'h2
`define MCR_PAIRS_1 3'h1
`define MCR_PAIRS_2 3'h2
`define MCR_PAIRS_4 3'h4
`define MCR_TX_OFS_LOW 5'h10
`define MCR_TX_OFS_HIGH 5'h0F
`define MCR_BAUD_DIV_LAST 3'h7
`define MCR_PN9_SEED 9'h1FF
`define MCR_RESP_OKAY 2'h0
`define MCR_RESP_SLVERR 2'h2

`endif

// *** hw/mcr_modem_config.v ***
// Modem configuration register bank with AXI4-Lite access
//
// How it works
// - ADC divisor codes 1-7 divide 4..16; 0 acts as 3
// - Scramble enable scrambles TX and RX with x^9+x^5+1
// - Format 00 selects NRZ, 01 Manchester, reset 00
// - Formats 10/11 UART, bit clock held 0/1
// - Deviation bit 7 enables Gaussian shaping, resets 1
// - TX deviation exponent offset 16 low, 15 high band
// - Zero TX mantissa selects on-off keying
// - Settling code 0 disables frequency correction
// - Codes 1,2,3 average over 1,2,4 bit pairs
// - RX deviation uses exponent minus 3, divided by 3
// - ADC clock is four times intermediate frequency
// - Baud tick is modem clock divided by eight
`timescale 1ns/1ns
`include "mcr_consts.vh"

module mcr_modem_config (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Modem timing
  input wire modem_clk_en,
  input wire bit_clk_in,
  input wire upper_band,
  output reg adc_clk_en,
  output reg adc_clk,
  output reg baud_tick,
  output reg bit_clock_output,
  // Transmit path
  input wire tx_bit,
  input wire tx_bit_valid,
  output reg tx_line,
  output reg tx_line_valid,
  // Receive path
  input wire rx_bit,
  input wire rx_bit_valid,
  output reg rx_data,
  output reg rx_data_valid,
  // Decoded configuration
  output reg manchester_mode,
  output reg uart_mode,
  output reg tx_shaping,
  output reg ook_mode,
  output reg [2:0] tx_dev_exponent,
  output reg [3:0] tx_dev_mantissa,
  output reg [4:0] tx_dev_offset,
  output reg afc_enable,
  output reg [2:0] afc_pairs,
  output reg [1:0] rx_dev_exponent,
  output reg [3:0] rx_dev_mantissa
);

  // Register storage
  reg [7:0] modem_control;
  reg [7:0] tx_deviation;
  reg [7:0] freq_correction_control;

  // Write channel holding
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [7:0] w_data;
  reg w_lane0;

  // Timing counters
  reg [3:0] adc_count;
  reg [2:0] baud_count;

  // Scrambler links
  wire [1:0] scr_in;
  wire [1:0] scr_valid;
  wire [1:0] scr_out;
  wire [1:0] scr_out_valid;
  wire [17:0] scr_state;

  wire scramble_enable;
  wire [1:0] data_format;
  wire [2:0] adc_code;
  wire [3:0] adc_half;
  wire do_write;
  wire [7:0] status_byte;

  // Effective ADC code, unsupported 0 falls back to 3
  function [2:0] adc_effective;
    input [2:0] code;
    begin
      adc_effective = (code == `MCR_ADC_UNSUP) ? `MCR_ADC_FALLBACK : code;
    end
  endfunction

  // Address to mapped-register check, used by both channels
  function mapped;
    input [7:0] addr;
    begin
      if (addr == `MCR_ADDR_MODEM || addr == `MCR_ADDR_DEV || addr == `MCR_ADDR_AFC || addr == `MCR_ADDR_STATUS)
        mapped = 1'b1;
      else
        mapped = 1'b0;
    end
  endfunction

  assign scramble_enable = modem_control[`MCR_SCR_BIT];
  assign data_format = modem_control[`MCR_FMT_HI:`MCR_FMT_LO];
  assign adc_code = adc_effective(modem_control[`MCR_ADC_HI:`MCR_ADC_LO]);
  // Divide by 2*code+2, so the half period is code+1 cycles
  assign adc_half = {1'b0, adc_code} + 4'h1;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign status_byte = {tx_line, rx_data, adc_clk, bit_clock_output,
                        ook_mode, uart_mode, manchester_mode, afc_enable};

  // Write address and data are caught independently, in either order
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MCR_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Status is read-only, so writing it is an error
        if (mapped(aw_addr) && aw_addr != `MCR_ADDR_STATUS)
          s_axi_bresp <= `MCR_RESP_OKAY;
        else
          s_axi_bresp <= `MCR_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Register file; reserved modem bits are dropped so they read zero
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      modem_control <= `MCR_RST_MODEM;
      tx_deviation <= `MCR_RST_DEV;
      freq_correction_control <= `MCR_RST_AFC;
    end
    else if (do_write && w_lane0)
    begin
      if (aw_addr == `MCR_ADDR_MODEM)
        modem_control <= w_data & `MCR_MODEM_WMASK;
      else if (aw_addr == `MCR_ADDR_DEV)
        tx_deviation <= w_data;
      else if (aw_addr == `MCR_ADDR_AFC)
        freq_correction_control <= w_data;
    end
  end

  // Read channel; one read in flight at a time
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `MCR_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped(s_axi_araddr) ? `MCR_RESP_OKAY : `MCR_RESP_SLVERR;
        if (s_axi_araddr == `MCR_ADDR_MODEM)
          s_axi_rdata <= {24'h000000, modem_control};
        else if (s_axi_araddr == `MCR_ADDR_DEV)
          s_axi_rdata <= {24'h000000, tx_deviation};
        else if (s_axi_araddr == `MCR_ADDR_AFC)
          s_axi_rdata <= {24'h000000, freq_correction_control};
        else if (s_axi_araddr == `MCR_ADDR_STATUS)
          s_axi_rdata <= {6'h00, scr_state, status_byte};
        else
          s_axi_rdata <= 32'h00000000;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ADC clock: the crystal clock here is core_clk; the IF is a quarter of adc_clk
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      adc_count <= 4'h0;
      adc_clk <= 1'b0;
      adc_clk_en <= 1'b0;
    end
    else
    begin
      adc_clk_en <= 1'b0;
      adc_count <= adc_count + 4'h1;
      // Compared with >= so a smaller divisor takes hold without running the counter round
      if (adc_count >= adc_half - 4'h1)
      begin
        adc_count <= 4'h0;
        adc_clk <= !adc_clk;
        adc_clk_en <= !adc_clk;
      end
    end
  end

  // Baud tick every eighth modem clock enable
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      baud_count <= 3'h0;
      baud_tick <= 1'b0;
    end
    else
    begin
      baud_count <= baud_count + {2'h0, modem_clk_en};
      baud_tick <= modem_clk_en && (baud_count == `MCR_BAUD_DIV_LAST);
    end
  end

  // One scrambler per direction
  assign scr_in = {rx_bit, tx_bit};
  assign scr_valid = {rx_bit_valid, tx_bit_valid};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_scr
      mcr_scrambler u_scr (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .enable(scramble_enable),
        .bit_in(scr_in[gi]),
        .bit_valid(scr_valid[gi]),
        .bit_out(scr_out[gi]),
        .bit_out_valid(scr_out_valid[gi]),
        .state(scr_state[gi * 9 + 8:gi * 9])
      );
    end
  endgenerate

  // Line coding and bit clock output
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_line <= 1'b0;
      tx_line_valid <= 1'b0;
      rx_data <= 1'b0;
      rx_data_valid <= 1'b0;
      bit_clock_output <= 1'b0;
    end
    else
    begin
      tx_line_valid <= scr_out_valid[0];
      rx_data <= scr_out[1];
      rx_data_valid <= scr_out_valid[1];
      // Manchester XORs each bit with the bit clock phase; NRZ and UART pass bits straight
      tx_line <= (data_format == `MCR_FMT_MAN) ? (scr_out[0] ^ bit_clk_in) : scr_out[0];
      if (data_format == `MCR_FMT_UART0)
        bit_clock_output <= 1'b0;
      else if (data_format == `MCR_FMT_UART1)
        bit_clock_output <= 1'b1;
      else
        bit_clock_output <= bit_clk_in;
    end
  end

  // Decoded configuration, registered so every output is a flop
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      manchester_mode <= 1'b0;
      uart_mode <= 1'b0;
      tx_shaping <= 1'b1;
      ook_mode <= 1'b0;
      tx_dev_exponent <= 3'h0;
      tx_dev_mantissa <= 4'h0;
      tx_dev_offset <= `MCR_TX_OFS_LOW;
      afc_enable <= 1'b0;
      afc_pairs <= 3'h0;
      rx_dev_exponent <= 2'h0;
      rx_dev_mantissa <= 4'h0;
    end
    else
    begin
      manchester_mode <= (data_format == `MCR_FMT_MAN);
      uart_mode <= data_format[1];
      tx_shaping <= tx_deviation[`MCR_SHAPE_BIT];
      tx_dev_exponent <= tx_deviation[`MCR_TXX_HI:`MCR_TXX_LO];
      tx_dev_mantissa <= tx_deviation[`MCR_TXM_HI:`MCR_TXM_LO];
      // Exponent is reduced by this offset when scaling the reference
      tx_dev_offset <= upper_band ? `MCR_TX_OFS_HIGH : `MCR_TX_OFS_LOW;
      ook_mode <= (tx_deviation[`MCR_TXM_HI:`MCR_TXM_LO] == 4'h0);
      rx_dev_exponent <= freq_correction_control[`MCR_RXX_HI:`MCR_RXX_LO];
      rx_dev_mantissa <= freq_correction_control[`MCR_RXM_HI:`MCR_RXM_LO];
      afc_enable <= (freq_correction_control[`MCR_SET_HI:`MCR_SET_LO] != `MCR_SET_OFF);
      if (freq_correction_control[`MCR_SET_HI:`MCR_SET_LO] == `MCR_SET_OFF)
        afc_pairs <= 3'h0;
      else if (freq_correction_control[`MCR_SET_HI:`MCR_SET_LO] == `MCR_SET_ONE)
        afc_pairs <= `MCR_PAIRS_1;
      else if (freq_correction_control[`MCR_SET_HI:`MCR_SET_LO] == `MCR_SET_TWO)
        afc_pairs <= `MCR_PAIRS_2;
      else
        afc_pairs <= `MCR_PAIRS_4;
    end
  end

endmodule

// *** hw/mcr_scrambler.v ***
// Nine-stage pseudo-random bit scrambler for one bit stream
`timescale 1ns/1ns
`include "mcr_consts.vh"

module mcr_scrambler (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Control
  input wire enable,
  // Bit stream in
  input wire bit_in,
  input wire bit_valid,
  // Bit stream out
  output reg bit_out,
  output reg bit_out_valid,
  output wire [8:0] state
);

  reg [8:0] lfsr;
  wire feedback;

  // Taps for x^9 + x^5 + 1
  assign feedback = lfsr[8] ^ lfsr[4];
  assign state = lfsr;

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lfsr <= `MCR_PN9_SEED;
      bit_out <= 1'b0;
      bit_out_valid <= 1'b0;
    end
    else
    begin
      bit_out_valid <= bit_valid;
      if (bit_valid)
      begin
        bit_out <= enable ? (bit_in ^ lfsr[8]) : bit_in;
      end
      // Disabled reloads the seed so both ends restart in step
      if (!enable)
      begin
        lfsr <= `MCR_PN9_SEED;
      end
      else if (bit_valid)
      begin
        lfsr <= {lfsr[7:0], feedback};
      end
    end
  end

endmodule
